// ===== hw/ucac_consts.vh
// constants for the alpha field codec
`ifndef UCAC_CONSTS_VH
`define UCAC_CONSTS_VH
`define UCAC_TAG_WIDE 8'h80
`define UCAC_TAG_HALF 8'h81
`define UCAC_TAG_FULL 8'h82
`define UCAC_PAD 8'hFF
`define UCAC_ST_TAG 4'h0
`define UCAC_ST_HI 4'h1
`define UCAC_ST_LO 4'h2
`define UCAC_ST_CNT 4'h3
`define UCAC_ST_B1 4'h4
`define UCAC_ST_B2 4'h5
`define UCAC_ST_BODY 4'h6
`define UCAC_ST_DEF 4'h7
`define UCAC_ST_PAD 4'h8
`define UCAC_ST_SKIP 4'h9
`define UCAC_WORD_W 17
`endif

// ===== hw/ucac_skid_buffer.v
// two-entry buffer between decoder and character sink
`timescale 1ns/1ps
`include "ucac_consts.vh"
module ucac_skid_buffer (
	// clock and reset
	input wire clk,
	input wire arst_n,
	// fill side
	input wire inValid,
	output wire inReady,
	input wire [`UCAC_WORD_W-1:0] inWord,
	// drain side
	output wire outValid,
	input wire outReady,
	output wire [`UCAC_WORD_W-1:0] outWord
);
	reg [1:0] count_q;
	reg [`UCAC_WORD_W-1:0] e0_q;
	reg [`UCAC_WORD_W-1:0] e1_q;
	wire push;
	wire pop;
	assign inReady = (count_q != 2'h2);
	assign outValid = (count_q != 2'h0);
	assign outWord = e0_q;
	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count_q <= 2'h0;
			e0_q <= {`UCAC_WORD_W{1'b0}};
			e1_q <= {`UCAC_WORD_W{1'b0}};
		end else begin
			case (count_q)
			2'h0: begin
				if (push) begin
					e0_q <= inWord;
					count_q <= 2'h1;
				end
			end
			2'h1: begin
				if (push && pop) begin
					e0_q <= inWord;
				end else if (push) begin
					e1_q <= inWord;
					count_q <= 2'h2;
				end else if (pop) begin
					count_q <= 2'h0;
				end
			end
			default: begin
				if (pop) begin
					e0_q <= e1_q;
					count_q <= 2'h1;
				end
			end
			endcase
		end
	end
endmodule

// ===== hw/ucac_alpha_codec.v
// alpha field octet decoder and format checker for 16-bit characters
`timescale 1ns/1ps
`include "ucac_consts.vh"
// Operation
// - tag 80: octet pairs, first is upper
// - wide scheme padding and odd octet FF
// - tag 81: count, then base bits 14..7
// - half scheme: default char or base+offset
// - tag 82: count, then two-octet base
// - full scheme: default char or base+offset
// - stop after count; FF inside is offset
// - tagged record of default chars only flagged
// - one coding form per record only
// - all three schemes decoded here
module ucac_alpha_codec (
	// clock and reset
	input wire clk,
	input wire arst_n,
	// octet stream in
	input wire inValid,
	output wire inReady,
	input wire [7:0] inOctet,
	input wire inLast,
	// character stream out
	output wire outValid,
	input wire outReady,
	output wire [15:0] outChar,
	output wire outIsUcs2,
	// record status
	output reg recDone_q,
	output reg recError_q
);
	reg [3:0] state_q;
	reg [3:0] state_d;
	reg [7:0] upperCharByte_q;
	reg [15:0] base_q;
	reg [15:0] base_d;
	reg [7:0] count_q;
	reg [7:0] count_d;
	reg strictPad_q;
	reg strictPad_d;
	reg wideSeen_q;
	reg wideSeen_d;
	reg charSeen_q;
	reg charSeen_d;
	reg err_q;
	reg err_d;
	reg emit;
	reg [15:0] emitChar;
	reg emitWide;
	wire bufReady;
	wire take;
	wire [15:0] pairChar;

	function [15:0] offsetChar;
		input [15:0] base;
		input [7:0] oct;
		begin
			if (oct[7])
				offsetChar = base + {9'h000, oct[6:0]};
			else
				offsetChar = {9'h000, oct[6:0]};
		end
	endfunction

	// whole stream stalls on the buffer; simpler than per-state ready
	assign inReady = bufReady;
	assign take = inValid && inReady;
	assign pairChar = {upperCharByte_q, inOctet};

	always @* begin
		state_d = state_q;
		base_d = base_q;
		count_d = count_q;
		strictPad_d = strictPad_q;
		wideSeen_d = wideSeen_q;
		charSeen_d = charSeen_q;
		err_d = err_q;
		emit = 1'b0;
		emitChar = 16'h0000;
		emitWide = 1'b0;
		case (state_q)
		`UCAC_ST_TAG: begin
			strictPad_d = 1'b0;
			wideSeen_d = 1'b0;
			charSeen_d = 1'b0;
			err_d = 1'b0;
			base_d = 16'h0000;
			if (inOctet == `UCAC_TAG_WIDE) begin
				strictPad_d = 1'b1;
				state_d = `UCAC_ST_HI;
			end else if (inOctet == `UCAC_TAG_HALF) begin
				// low base bit marks the half scheme until B2 rewrites it
				base_d = 16'h0001;
				state_d = `UCAC_ST_CNT;
			end else if (inOctet == `UCAC_TAG_FULL) begin
				state_d = `UCAC_ST_CNT;
			end else if (inOctet == `UCAC_PAD) begin
				state_d = `UCAC_ST_PAD;
			end else begin
				emit = 1'b1;
				// default chars are seven bits; a stray top bit is flagged
				emitChar = {9'h000, inOctet[6:0]};
				state_d = `UCAC_ST_DEF;
				// no top bit in default form
				if (inOctet[7])
					err_d = 1'b1;
			end
		end
		`UCAC_ST_HI: begin
			state_d = `UCAC_ST_LO;
			// odd trailing octet must be FF
			if (inLast && inOctet != `UCAC_PAD)
				err_d = 1'b1;
		end
		`UCAC_ST_LO: begin
			if (pairChar == 16'hFFFF) begin
				state_d = `UCAC_ST_PAD;
			end else begin
				emit = 1'b1;
				emitChar = pairChar;
				emitWide = 1'b1;
				charSeen_d = 1'b1;
				if (pairChar[15:7] != 9'h000)
					wideSeen_d = 1'b1;
				state_d = `UCAC_ST_HI;
			end
		end
		`UCAC_ST_CNT: begin
			count_d = inOctet;
			state_d = base_q[0] ? `UCAC_ST_B2 : `UCAC_ST_B1;
		end
		`UCAC_ST_B1: begin
			base_d = {inOctet, 8'h00};
			state_d = `UCAC_ST_B2;
		end
		`UCAC_ST_B2: begin
			if (base_q[0]) begin
				// bits 14..7 from octet, rest zero
				base_d = {1'b0, inOctet, 7'h00};
			end else begin
				base_d = {base_q[15:8], inOctet};
			end
			state_d = (count_q == 8'h00) ? `UCAC_ST_SKIP : `UCAC_ST_BODY;
		end
		`UCAC_ST_BODY: begin
			// default char or offset from base
			// same coding on the full base
			emit = 1'b1;
			emitChar = offsetChar(base_q, inOctet);
			emitWide = inOctet[7];
			charSeen_d = 1'b1;
			if (inOctet[7])
				wideSeen_d = 1'b1;
			// count ends the string, FF included
			count_d = count_q - 8'h01;
			if (count_q == 8'h01)
				state_d = `UCAC_ST_SKIP;
		end
		`UCAC_ST_DEF: begin
			if (inOctet == `UCAC_PAD) begin
				state_d = `UCAC_ST_PAD;
			end else begin
				emit = 1'b1;
				emitChar = {9'h000, inOctet[6:0]};
				if (inOctet[7])
					err_d = 1'b1;
			end
		end
		`UCAC_ST_PAD: begin
			if (strictPad_q && inOctet != `UCAC_PAD)
				err_d = 1'b1;
		end
		`UCAC_ST_SKIP: begin
			state_d = `UCAC_ST_SKIP;
		end
		default: begin
			state_d = `UCAC_ST_TAG;
		end
		endcase
		if (inLast) begin
			state_d = `UCAC_ST_TAG;
			// field ended before the count was met
			if (state_q == `UCAC_ST_CNT || state_q == `UCAC_ST_B1 ||
				state_q == `UCAC_ST_B2 ||
				(state_q == `UCAC_ST_BODY && count_q != 8'h01))
				err_d = 1'b1;
			if (charSeen_d && !wideSeen_d && state_q != `UCAC_ST_TAG &&
				state_q != `UCAC_ST_DEF && state_q != `UCAC_ST_PAD)
				err_d = 1'b1;
			if (state_q == `UCAC_ST_PAD && strictPad_q && charSeen_q &&
				!wideSeen_q)
				err_d = 1'b1;
		end
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= `UCAC_ST_TAG;
			upperCharByte_q <= 8'h00;
			base_q <= 16'h0000;
			count_q <= 8'h00;
			strictPad_q <= 1'b0;
			wideSeen_q <= 1'b0;
			charSeen_q <= 1'b0;
			err_q <= 1'b0;
			recDone_q <= 1'b0;
			recError_q <= 1'b0;
		end else begin
			recDone_q <= 1'b0;
			if (take) begin
				state_q <= state_d;
				base_q <= base_d;
				count_q <= count_d;
				strictPad_q <= strictPad_d;
				wideSeen_q <= wideSeen_d;
				charSeen_q <= charSeen_d;
				err_q <= err_d;
				if (state_q == `UCAC_ST_HI)
					upperCharByte_q <= inOctet;
				if (inLast) begin
					recDone_q <= 1'b1;
					recError_q <= err_d;
				end
			end
		end
	end

	// characters carry a wide flag through the buffer
	ucac_skid_buffer u_buf (
		.clk(clk),
		.arst_n(arst_n),
		.inValid(take && emit),
		.inReady(bufReady),
		.inWord({emitWide, emitChar}),
		.outValid(outValid),
		.outReady(outReady),
		.outWord({outIsUcs2, outChar})
	);
endmodule

// ===== sim/ucac_alpha_codec_properties.sv
// port assertions for the alpha field codec
`timescale 1ns/1ps
module ucac_props (
	// clock and reset
	input wire clk,
	input wire arst_n,
	// octet side
	input wire inValid,
	input wire inReady,
	input wire [7:0] inOctet,
	input wire inLast,
	// character side
	input wire outValid,
	input wire outReady,
	input wire [15:0] outChar,
	input wire outIsUcs2,
	// status
	input wire recDone_q,
	input wire recError_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence s_stall;
		outValid && !outReady;
	endsequence
	sequence s_takeLast;
		inValid && inReady && inLast;
	endsequence
	property p_hold;
		s_stall |=> outValid && $stable(outChar) && $stable(outIsUcs2);
	endproperty
	property p_done;
		s_takeLast |=> recDone_q;
	endproperty
	property p_doneCause;
		recDone_q |-> $past(inValid && inReady && inLast);
	endproperty
	property p_err;
		$changed(recError_q) |-> recDone_q;
	endproperty
	property p_def;
		outValid && !outIsUcs2 |-> outChar[15:7] == 9'h000;
	endproperty
	property p_rose;
		$rose(outValid) |-> $past(inValid && inReady);
	endproperty
	property p_refuse;
		!inReady |-> outValid;
	endproperty
	property p_full;
		!inReady && !outReady |=> !inReady;
	endproperty
	property p_drain;
		!inReady && outReady |=> inReady;
	endproperty
	a_hold: assert property (p_hold) else $error("char dropped");
	a_done: assert property (p_done) else $error("no done");
	a_doneCause: assert property (p_doneCause) else $error("stray done");
	a_err: assert property (p_err) else $error("error moved");
	a_def: assert property (p_def) else $error("default char wide");
	a_rose: assert property (p_rose) else $error("char uncaused");
	a_refuse: assert property (p_refuse) else $error("bad refusal");
	a_full: assert property (p_full) else $error("full lost");
	a_drain: assert property (p_drain) else $error("no room");
endmodule
bind ucac_alpha_codec ucac_props ucac_props_i (
	.clk(clk),
	.arst_n(arst_n),
	.inValid(inValid),
	.inReady(inReady),
	.inOctet(inOctet),
	.inLast(inLast),
	.outValid(outValid),
	.outReady(outReady),
	.outChar(outChar),
	.outIsUcs2(outIsUcs2),
	.recDone_q(recDone_q),
	.recError_q(recError_q)
);

// ===== sim/ucac_sink.sv
// character sink model, prompt or slow
`timescale 1ns/1ps
module ucac_sink (
	// clock and reset
	input wire clk,
	input wire arst_n,
	// character stream
	input wire outValid,
	output reg outReady,
	input wire [15:0] outChar,
	input wire outIsUcs2,
	// pacing: slow takes one char in four
	input wire slow
);
	logic [16:0] got[$];
	logic [1:0] cnt;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			outReady <= 1'b0;
			cnt <= 2'h0;
		end else begin
			cnt <= cnt + 2'h1;
			outReady <= !slow || cnt == 2'h3;
			if (outValid && outReady)
				got.push_back({outIsUcs2, outChar});
		end
	end
endmodule

// ===== sim/tb.sv
// self-checking bench for the alpha field codec
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic inValid = 1'b0;
	logic [7:0] inOctet = 8'h00;
	logic inLast = 1'b0;
	logic slow = 1'b0;
	wire inReady, outValid, outReady, outIsUcs2, recDone_q, recError_q;
	wire [15:0] outChar;
	int mismatches = 0;
	int n_tests = 0;
	int cyc = 0;
	always #5 clk = ~clk;
	ucac_alpha_codec ucac_alpha_codec_i (
		.clk(clk),
		.arst_n(arst_n),
		.inValid(inValid),
		.inReady(inReady),
		.inOctet(inOctet),
		.inLast(inLast),
		.outValid(outValid),
		.outReady(outReady),
		.outChar(outChar),
		.outIsUcs2(outIsUcs2),
		.recDone_q(recDone_q),
		.recError_q(recError_q)
	);
	ucac_sink ucac_sink_i (
		.clk(clk),
		.arst_n(arst_n),
		.outValid(outValid),
		.outReady(outReady),
		.outChar(outChar),
		.outIsUcs2(outIsUcs2),
		.slow(slow)
	);
	task end_sim();
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// a hang counts as a mismatch
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			mismatches++;
			end_sim();
		end
	end
	task chk(input logic [16:0] g, input logic [16:0] e);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task snd(input logic [7:0] b, input logic l);
		inValid <= 1'b1;
		inOctet <= b;
		inLast <= l;
		@(posedge clk);
		while (inReady !== 1'b1)
			@(posedge clk);
		if (l)
			inValid <= 1'b0;
	endtask
	task run(input string nm, input logic [7:0] o[$],
		input logic [16:0] e[$], input logic er);
		int i;
		ucac_sink_i.got.delete();
		@(posedge clk);
		foreach (o[k])
			snd(o[k], k == o.size() - 1);
		i = 0;
		@(negedge clk);
		while (recDone_q !== 1'b1 && i < 20) begin
			@(negedge clk);
			i++;
		end
		chk({16'h0000, recDone_q}, 17'h00001);
		chk({16'h0000, recError_q}, {16'h0000, er});
		repeat (30) @(negedge clk);
		chk(17'(ucac_sink_i.got.size()), 17'(e.size()));
		foreach (e[k])
			chk(ucac_sink_i.got[k], e[k]);
		$display("test %s done", nm);
	endtask
	task t_half();
		run("half", '{8'h81, 8'h05, 8'h13, 8'h53, 8'h95, 8'hA6, 8'h41,
			8'hFF, 8'hFF}, '{17'h00053, 17'h10995, 17'h109A6,
			17'h00041, 17'h109FF}, 1'b0);
	endtask
	task t_full();
		run("full", '{8'h82, 8'h05, 8'h05, 8'h30, 8'h2D, 8'h82, 8'hD3,
			8'h2D, 8'h31}, '{17'h0002D, 17'h10532, 17'h10583,
			17'h0002D, 17'h00031}, 1'b0);
	endtask
	task t_wide();
		run("wide", '{8'h80, 8'h09, 8'h95, 8'h00, 8'h41, 8'hFF, 8'hFF,
			8'hFF}, '{17'h10995, 17'h10041}, 1'b0);
	endtask
	task t_badPad();
		run("badpad", '{8'h80, 8'h09, 8'h95, 8'hFF, 8'hFF, 8'h00, 8'h41},
			'{17'h10995}, 1'b1);
	endtask
	task t_odd();
		run("odd", '{8'h80, 8'h00, 8'hE9, 8'h41}, '{17'h100E9}, 1'b1);
	endtask
	task t_mixed();
		run("mixed", '{8'h41, 8'hC1, 8'hFF}, '{17'h00041, 17'h00041},
			1'b1);
	endtask
	task t_plain();
		run("plain", '{8'h41, 8'h42, 8'hFF, 8'hFF},
			'{17'h00041, 17'h00042}, 1'b0);
	endtask
	task t_needless();
		run("needless", '{8'h81, 8'h01, 8'h00, 8'h41}, '{17'h00041}, 1'b1);
	endtask
	task t_short();
		run("short", '{8'h82, 8'h03, 8'h00, 8'h80, 8'hC1},
			'{17'h100C1}, 1'b1);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		slow <= 1'b1;
		t_half();
		t_full();
		slow <= 1'b0;
		t_wide();
		t_badPad();
		t_odd();
		t_mixed();
		t_plain();
		t_needless();
		t_short();
		end_sim();
	end
endmodule
